// [dv/reset_strap_peripheral_select_test.sv]
`timescale 1ns/1ps
`include "strap_defines.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
// ====================
// bench
module reset_strap_peripheral_select_test;
	logic sys_clk_i = 0, rst_b_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, hold_i = 1;
	logic [10:0] cfg_i = '0;
	logic [31:0] cfg_addr_i = '0, cfg_wdata_i = '0, cfg_rdata_o, peripheral_config_o;
	logic pci_sel_strap_i, eeprom_autoinit_strap_i, host_width_strap_i, mac_sel_strap_i;
	logic endian_strap_i, pci_frequency_strap_i, reserved_low_strap_i;
	logic [3:0] ext_addr_strap_pins_i;
	logic host_port_en_o, host_port_32bit_o, host_upper_data_z_o, host_upper_data_mac_o;
	logic host_lower_data_z_o, pci_en_o, pci_only_pins_z_o, eeprom_load_o, pci_33mhz_o;
	logic ethernet_mac_en_o, upper_gpio_pins_en_o, lower_gpio_pins_en_o, timers_en_o;
	logic serial_ctrl_en_o, little_endian_o, invalid_cfg_o, straps_valid_o;
	strap_pkg::boot_mode_t boot_mode_o;
	strap_pkg::eclk_sel_t eclk_sel_o;
	int n_mismatch = 0, checks_done = 0, cycles = 0;
	reset_strap_peripheral_select dut (.*);
	strap_board board (.*);
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	function automatic logic [10:0] sel();
		return {host_port_en_o, host_port_32bit_o, host_upper_data_z_o, host_upper_data_mac_o,
			host_lower_data_z_o, pci_en_o, pci_only_pins_z_o, ethernet_mac_en_o,
			upper_gpio_pins_en_o, eeprom_load_o, pci_33mhz_o};
	endfunction
	function automatic logic [8:0] misc();
		return {little_endian_o, boot_mode_o, eclk_sel_o, invalid_cfg_o, lower_gpio_pins_en_o,
			timers_en_o, serial_ctrl_en_o};
	endfunction
	task automatic complete_run();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// straps held through reset, then pins go busy
	task automatic apply(input logic [10:0] c);
		int k;
		@(negedge sys_clk_i);
		hold_i = 1;
		cfg_i = c;
		rst_b_i = 0;
		repeat (2) @(negedge sys_clk_i);
		rst_b_i = 1;
		for (k = 0; k < 20 && straps_valid_o !== 1'b1; k++)
			@(negedge sys_clk_i);
		`CHK("valid", 1'b1, straps_valid_o)
		hold_i = 0;
		repeat (3) @(negedge sys_clk_i);
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(negedge sys_clk_i);
		cfg_wr_i = wr;
		cfg_rd_i = !wr;
		cfg_addr_i = a;
		cfg_wdata_i = d;
		@(negedge sys_clk_i);
		cfg_wr_i = 0;
		cfg_rd_i = 0;
	endtask
	task automatic t_host();
		logic [1:0] m;
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			apply({2'b01, 4'h0, 1'b1, m[0], m[1], 2'b10});
			`CHK("host", {m != 3, m == 2, m == 0, m[0], m == 3, 2'b01, m[0], 3'b100}, sel())
		end
	endtask
	task automatic t_pci();
		for (int i = 0; i < 4; i++)
		begin
			apply({1'b0, i[1], 4'h0, 1'b0, 2'b11, i[0], 1'b1});
			`CHK("pci", {5'h00, 4'h8, i[0], i[1]}, sel())
		end
	endtask
	task automatic t_misc();
		logic [1:0] m;
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			apply({m == 3, 1'b0, m, ~m, m[0], 4'h0});
			`CHK("misc", {m[0], m, ~m, m == 3, 3'b111}, misc())
		end
	endtask
	task automatic t_reg();
		`CHK("cfg rst", `PERIPHERAL_CONFIG_RESET, peripheral_config_o)
		bus(1'b1, `PERIPHERAL_CONFIG_ADDR, 32'hA5C35AF0);
		`CHK("cfg wr", 32'hA5C35AF0 & `PERIPHERAL_CONFIG_WMASK, peripheral_config_o)
		bus(1'b1, `PERIPHERAL_CONFIG_ADDR + 32'h4, 32'h00001234);
		`CHK("cfg ign", 32'h00005AF0, peripheral_config_o)
		bus(1'b0, `PERIPHERAL_CONFIG_ADDR, 32'h0);
		`CHK("cfg rd", 16'h5AF0, cfg_rdata_o[15:0])
		`CHK("cfg st", 16'h0470, cfg_rdata_o[31:16])
		bus(1'b0, `PERIPHERAL_CONFIG_ADDR + 32'h4, 32'h0);
		`CHK("bad rd", 32'h0, cfg_rdata_o)
		apply(11'h000);
		`CHK("cfg rst2", `PERIPHERAL_CONFIG_RESET, peripheral_config_o)
	endtask
	initial
	begin
		t_host();
		t_pci();
		t_misc();
		t_reg();
		complete_run();
	end
endmodule // reset_strap_peripheral_select_test

// [dv/strap_board.sv]
`timescale 1ns/1ps
// ====================
// board straps; once released the pins carry other traffic
module strap_board
(
	input wire logic [10:0] cfg_i,
	input wire logic hold_i,
	output logic pci_sel_strap_i, eeprom_autoinit_strap_i, host_width_strap_i, mac_sel_strap_i,
	output logic endian_strap_i, pci_frequency_strap_i, reserved_low_strap_i,
	output logic [3:0] ext_addr_strap_pins_i
);
	// inverted after release so a late sample is caught
	assign {reserved_low_strap_i, pci_frequency_strap_i, ext_addr_strap_pins_i, endian_strap_i,
		mac_sel_strap_i, host_width_strap_i, eeprom_autoinit_strap_i,
		pci_sel_strap_i} = hold_i ? cfg_i : ~cfg_i;
endmodule // strap_board

// [dv/strap_monitor.sv]
`timescale 1ns/1ps
`include "strap_defines.svh"
// ====================
// strap selection and config register checks
module strap_monitor
(
	input wire logic sys_clk_i, rst_b_i, cfg_wr_i, cfg_rd_i, straps_valid_o,
	input wire logic [31:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o, peripheral_config_o,
	input wire logic host_port_en_o, host_port_32bit_o, host_upper_data_z_o, pci_en_o,
	input wire logic pci_only_pins_z_o, eeprom_load_o, ethernet_mac_en_o, upper_gpio_pins_en_o,
	input wire logic lower_gpio_pins_en_o, timers_en_o, serial_ctrl_en_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	pci_excl_a: assert property (straps_valid_o && pci_en_o |->
		!host_port_en_o && !ethernet_mac_en_o && !upper_gpio_pins_en_o) else $error("pci excl");
	host_on_a: assert property (straps_valid_o && !pci_en_o && !ethernet_mac_en_o |->
		host_port_en_o) else $error("host off");
	mac_narrow_a: assert property (ethernet_mac_en_o && host_port_en_o |->
		!host_port_32bit_o && !pci_en_o) else $error("mac with wide host");
	always_on_a: assert property (straps_valid_o |->
		lower_gpio_pins_en_o && timers_en_o && serial_ctrl_en_o) else $error("always on");
	strap_hold_a: assert property (straps_valid_o && $past(straps_valid_o) |->
		$stable({pci_en_o, host_port_en_o, ethernet_mac_en_o, eeprom_load_o})) else $error("hold");
	pci_tie_a: assert property (straps_valid_o |->
		pci_only_pins_z_o == !pci_en_o) else $error("pci tie");
	eeprom_pci_a: assert property (eeprom_load_o |-> pci_en_o) else $error("eeprom");
	upper_z_a: assert property (straps_valid_o && !pci_en_o |->
		host_upper_data_z_o == (!host_port_32bit_o && !ethernet_mac_en_o)) else $error("upper z");
	cfg_write_a: assert property (cfg_wr_i && cfg_addr_i == `PERIPHERAL_CONFIG_ADDR |=>
		peripheral_config_o == ($past(cfg_wdata_i) & `PERIPHERAL_CONFIG_WMASK)) else $error("cfg write");
	bad_read_a: assert property (cfg_rd_i && cfg_addr_i != `PERIPHERAL_CONFIG_ADDR |=>
		cfg_rdata_o == 32'h0) else $error("bad read");
endmodule // strap_monitor

bind reset_strap_peripheral_select strap_monitor mon (.*);

// [hdl/reset_strap_peripheral_select.sv]
// Summary of operation
// - latch pci and mac straps at reset
// - straps fixed; config register software writable
// - timers, serial, lower gpio always available
// - shared peripherals selected by straps; pci excludes host, mac and upper gpio
// - pci off: host port unless width and mac straps both set, width/mac choose
// - pci off: upper gpio usable by software
// - pci off: shared to host and/or mac per width/mac, pci-only hi-z
// - pci on: all shared pins to pci
// - pci on: eeprom strap selects eeprom load or defaults
// - width/mac code sets host pin usage
// - mac only without pci; host 16-bit, or host off when width strap also set
// - board straps; device latches all at reset
// - endian strap: 0 big, 1 little
// - boot strap decode none/host-pci/reserved/extmem
// - ext memory clock select decode
// - pci frequency strap: 0 66, 1 33
`timescale 1ns/1ps
`include "strap_defines.svh"
module reset_strap_peripheral_select
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic pci_sel_strap_i,
	input wire logic eeprom_autoinit_strap_i,
	input wire logic host_width_strap_i,
	input wire logic mac_sel_strap_i,
	input wire logic endian_strap_i,
	input wire logic [3:0] ext_addr_strap_pins_i,
	input wire logic pci_frequency_strap_i,
	input wire logic reserved_low_strap_i,
	input wire logic [31:0] cfg_addr_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic [31:0] peripheral_config_o,
	output logic host_port_en_o,
	output logic host_port_32bit_o,
	output logic host_upper_data_z_o,
	output logic host_upper_data_mac_o,
	output logic host_lower_data_z_o,
	output logic pci_en_o,
	output logic pci_only_pins_z_o,
	output logic eeprom_load_o,
	output logic pci_33mhz_o,
	output logic ethernet_mac_en_o,
	output logic upper_gpio_pins_en_o,
	output logic lower_gpio_pins_en_o,
	output logic timers_en_o,
	output logic serial_ctrl_en_o,
	output logic little_endian_o,
	output strap_pkg::boot_mode_t boot_mode_o,
	output strap_pkg::eclk_sel_t eclk_sel_o,
	output logic invalid_cfg_o,
	output logic straps_valid_o
);
	// ==========================================
	// reset release
	logic rst_s1_r, rst_s2_r;
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// ==========================================
	// strap capture and decode
	strap_if sif ();
	logic [`STRAP_W-1:0] pins;
	assign pins = {reserved_low_strap_i, pci_frequency_strap_i, ext_addr_strap_pins_i,
		endian_strap_i, mac_sel_strap_i, host_width_strap_i,
		eeprom_autoinit_strap_i, pci_sel_strap_i};

	strap_latch u_latch
	(
		.clk_i(sys_clk_i),
		.rst_n_i(rst_s2_r),
		.pins_i(pins),
		.sif(sif)
	);

	logic d_host_en, d_pci_en, d_eeprom, d_mac, d_ugpio, d_pciz, d_inv;
	logic [1:0] d_hmode;
	strap_decode u_dec
	(
		.sif(sif),
		.host_en_o(d_host_en),
		.host_mode_o(d_hmode),
		.pci_en_o(d_pci_en),
		.eeprom_ld_o(d_eeprom),
		.mac_en_o(d_mac),
		.upper_gpio_ok_o(d_ugpio),
		.pci_only_z_o(d_pciz),
		.invalid_o(d_inv)
	);

	// ==========================================
	// peripheral config register
	// strap selections are read-only; only the software word is writable
	logic [31:0] peripheral_config_r, peripheral_config_nxt, rdata_r, rdata_nxt;
	logic [`ST_W-1:0] status;
	assign status = {5'h00, d_inv, sif.straps[`S_PCI_FREQ], sif.straps[`S_ECLK_HI:`S_ECLK_LO],
		sif.straps[`S_BOOT_HI:`S_BOOT_LO], sif.straps[`S_ENDIAN], d_hmode, d_mac, d_pci_en};
	always_comb
	begin
		peripheral_config_nxt = peripheral_config_r;
		rdata_nxt = rdata_r;
		if (cfg_wr_i && cfg_addr_i == `PERIPHERAL_CONFIG_ADDR)
			peripheral_config_nxt = cfg_wdata_i & `PERIPHERAL_CONFIG_WMASK;
		if (cfg_rd_i)
			rdata_nxt = (cfg_addr_i == `PERIPHERAL_CONFIG_ADDR) ? {status, peripheral_config_r[`ST_W-1:0]} : 32'h00000000;
	end

	// ==========================================
	// output registers
	logic [18:0] out_r, out_nxt;
	always_comb
	begin
		out_nxt[0] = d_host_en;
		out_nxt[1] = d_host_en & (d_hmode == strap_pkg::HMODE_32);
		out_nxt[2] = ~d_pci_en & (d_hmode == strap_pkg::HMODE_16_UPZ);
		out_nxt[3] = ~d_pci_en & d_mac & (d_hmode != strap_pkg::HMODE_32);
		out_nxt[4] = ~d_pci_en & (d_hmode == strap_pkg::HMODE_Z_MAC);
		out_nxt[5] = d_pci_en;
		out_nxt[6] = d_pciz;
		out_nxt[7] = d_eeprom;
		out_nxt[8] = d_pci_en & sif.straps[`S_PCI_FREQ];
		out_nxt[9] = d_mac;
		out_nxt[10] = d_ugpio;
		out_nxt[11] = 1'b1;
		out_nxt[12] = sif.straps[`S_ENDIAN];
		out_nxt[14:13] = sif.straps[`S_BOOT_HI:`S_BOOT_LO];
		out_nxt[16:15] = sif.straps[`S_ECLK_HI:`S_ECLK_LO];
		out_nxt[17] = d_inv;
		out_nxt[18] = sif.valid;
	end
	always_ff @(posedge sys_clk_i or negedge rst_s2_r)
	begin
		if (!rst_s2_r)
		begin
			peripheral_config_r <= `PERIPHERAL_CONFIG_RESET;
			rdata_r <= 32'h00000000;
			out_r <= 19'h00000;
		end
		else
		begin
			peripheral_config_r <= peripheral_config_nxt;
			rdata_r <= rdata_nxt;
			out_r <= out_nxt;
		end
	end

	assign cfg_rdata_o = rdata_r;
	assign peripheral_config_o = peripheral_config_r;
	assign host_port_en_o = out_r[0];
	assign host_port_32bit_o = out_r[1];
	assign host_upper_data_z_o = out_r[2];
	assign host_upper_data_mac_o = out_r[3];
	assign host_lower_data_z_o = out_r[4];
	assign pci_en_o = out_r[5];
	assign pci_only_pins_z_o = out_r[6];
	assign eeprom_load_o = out_r[7];
	assign pci_33mhz_o = out_r[8];
	assign ethernet_mac_en_o = out_r[9];
	assign upper_gpio_pins_en_o = out_r[10];
	assign lower_gpio_pins_en_o = out_r[11];
	assign timers_en_o = out_r[11];
	assign serial_ctrl_en_o = out_r[11];
	assign little_endian_o = out_r[12];
	assign boot_mode_o = strap_pkg::boot_mode_t'(out_r[14:13]);
	assign eclk_sel_o = strap_pkg::eclk_sel_t'(out_r[16:15]);
	assign invalid_cfg_o = out_r[17];
	assign straps_valid_o = out_r[18];
endmodule // reset_strap_peripheral_select

// [hdl/strap_decode.sv]
`timescale 1ns/1ps
`include "strap_defines.svh"
module strap_decode
(
	strap_if.decode_side sif,
	output logic host_en_o,
	output logic [1:0] host_mode_o,
	output logic pci_en_o,
	output logic eeprom_ld_o,
	output logic mac_en_o,
	output logic upper_gpio_ok_o,
	output logic pci_only_z_o,
	output logic invalid_o
);
	// ==========================================
	// selection decode
	logic pci, hw, mac;
	always_comb
	begin
		pci = sif.straps[`S_PCI_SEL];
		hw = sif.straps[`S_HOST_W];
		mac = sif.straps[`S_MAC_SEL];
		host_mode_o = {hw, mac};
		pci_en_o = sif.valid & pci;
		eeprom_ld_o = sif.valid & pci & sif.straps[`S_EEPROM];
		host_en_o = sif.valid & ~pci & ~(hw & mac);
		mac_en_o = sif.valid & ~pci & mac;
		upper_gpio_ok_o = sif.valid & ~pci;
		pci_only_z_o = ~pci;
		invalid_o = sif.valid & sif.straps[`S_RSV_LOW];
	end
endmodule // strap_decode

// [hdl/strap_latch.sv]
`timescale 1ns/1ps
`include "strap_defines.svh"
module strap_latch
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [`STRAP_W-1:0] pins_i,
	strap_if.latch_side sif
);
	// ==========================================
	// pin synchroniser and reset-time capture
	logic [`STRAP_W-1:0] sync1_r, sync2_r, cap_r, cap_nxt;
	logic valid_r, valid_nxt;
	always_comb
	begin
		cap_nxt = cap_r;
		valid_nxt = 1'b1;
		// capture once, on the first cycle after release; held until next reset
		if (!valid_r)
			cap_nxt = sync2_r;
	end
	// sync runs through reset so the straps are settled when capture fires
	always_ff @(posedge clk_i)
	begin
		sync1_r <= pins_i;
		sync2_r <= sync1_r;
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cap_r <= '0;
			valid_r <= 1'b0;
		end
		else
		begin
			cap_r <= cap_nxt;
			valid_r <= valid_nxt;
		end
	end
	assign sif.straps = cap_r;
	assign sif.valid = valid_r;
endmodule // strap_latch

// [shared/strap_defines.svh]
`ifndef STRAP_DEFINES_SVH
`define STRAP_DEFINES_SVH

// register map
`define PERIPHERAL_CONFIG_ADDR 32'h01B3F000
`define PERIPHERAL_CONFIG_RESET 32'h00000000
`define PERIPHERAL_CONFIG_WMASK 32'h0000FFFF

// strap vector field positions
`define STRAP_W 11
`define S_PCI_SEL 0
`define S_EEPROM 1
`define S_HOST_W 2
`define S_MAC_SEL 3
`define S_ENDIAN 4
`define S_ECLK_LO 5
`define S_ECLK_HI 6
`define S_BOOT_LO 7
`define S_BOOT_HI 8
`define S_PCI_FREQ 9
`define S_RSV_LOW 10

// status word layout
`define ST_W 16

`endif

// [shared/strap_if.sv]
`timescale 1ns/1ps
interface strap_if;
	logic [10:0] straps;
	logic valid;
	modport latch_side (output straps, output valid);
	modport decode_side (input straps, input valid);
endinterface

// [shared/strap_pkg.sv]
package strap_pkg;
	typedef enum logic [1:0]
	{
		BOOT_NONE = 2'b00,
		BOOT_HOST_PCI = 2'b01,
		BOOT_RSVD = 2'b10,
		BOOT_EXTMEM = 2'b11
	} boot_mode_t;
	typedef enum logic [1:0]
	{
		ECLK_EXT = 2'b00,
		ECLK_DIV4 = 2'b01,
		ECLK_DIV6 = 2'b10,
		ECLK_RSVD = 2'b11
	} eclk_sel_t;
	typedef enum logic [1:0]
	{
		HMODE_16_UPZ = 2'b00,
		HMODE_16_MAC = 2'b01,
		HMODE_32 = 2'b10,
		HMODE_Z_MAC = 2'b11
	} host_mode_t;
endpackage
